// file: logic/udgc_top.sv
// usb device general control: apb registers, power states, irqs, endpoint memory map
`timescale 1ns/1ps
// Functional notes
// - any system reset disables and resets controller
// - cpu reset on bus reset keeps attached
// - reset state: off, frozen, pad suspended
// - enable enters idle; disable acts as reset
// - separate general and endpoint interrupt outputs
// - vbus and wakeup detected while frozen
// - eight enabled sources per endpoint, summary
// - any usb interrupt wakes idle cpu
// - wakeup or vbus interrupt wakes powerdown
// - frozen: general and device registers only, two irqs
// - freeze stops clocks, resume detect stays
// - low speed selects d minus pull-up
// - reserve inserts, next higher slides up
// - disable keeps config; free slides next down
// - endpoint zero never moved; reenable no slide
// - config ok set despite overlap
// - suspend idles pad; activity wakes it
// - detach idles pad, attach reactivates
// - vbus status follows session valid
// - vbus change flags; no attach without vbus
// - vbus pad enable works while disabled
module udgc_top
  import udgc_pkg::*;
#(
  parameter int NUM_EP = 7
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // usb link side events
  input wire logic [1:0] LINE_STATE,
  input wire logic SUSPEND_DET,
  input wire logic BUS_RESET_END,
  input wire logic VBUS_SESSION_VALID,
  input wire logic [NUM_EP*EP_SRC_COUNT-1:0] EP_EVENT,
  // interrupts and wake
  output logic IRQ_GENERAL,
  output logic IRQ_ENDPOINT,
  output logic CPU_WAKE,
  output logic SYS_WAKE,
  output logic CPU_RESET_REQ,
  // pad and clock control
  output logic XCVR_ON,
  output logic CTRL_CLOCK_EN,
  output logic PAD_IDLE,
  output logic PULLUP_DP,
  output logic PULLUP_DM,
  output logic VBUS_PAD_ON,
  output logic PAD_REG_ON
);

  localparam int EPW = (NUM_EP > 1) ? $clog2(NUM_EP) : 1;

  typedef enum logic [1:0] {MODE_RESET, MODE_IDLE, MODE_SUSPENDED} udgc_mode_type;

  typedef struct packed {
    logic macro_enable;
    logic clock_freeze;
    logic vbus_pad_enable;
    logic vbus_transition_irq_enable;
    logic pad_regulator_enable;
    logic vbus_status;
    logic vbus_transition_flag;
    logic detach;
    logic low_speed_select;
    logic cpu_reset_enable;
    logic suspend_flag;
    logic end_of_reset_flag;
    logic wakeup_flag;
    logic suspend_ie;
    logic end_of_reset_ie;
    logic wakeup_ie;
    udgc_mode_type mode;
    logic [1:0] line_prev;
    logic [EPW-1:0] ep_sel;
    logic [NUM_EP-1:0] endpoint_enable;
    logic [NUM_EP-1:0] memory_reserve_bit;
    logic [NUM_EP-1:0] endpoint_bank_count;
    logic [NUM_EP-1:0] configuration_ok_flag;
    logic [NUM_EP-1:0][2:0] endpoint_size_field;
    logic [NUM_EP-1:0][10:0] ep_base;
    logic [NUM_EP-1:0][7:0] ep_flag;
    logic [NUM_EP-1:0][7:0] ep_ien;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq_gen;
    logic irq_ep;
    logic cpu_wake;
    logic sys_wake;
    logic cpu_rst;
    logic xcvr_on;
    logic clk_en;
    logic pad_idle;
    logic pu_dp;
    logic pu_dm;
  } udgc_state_type;

  udgc_state_type r;
  udgc_state_type next_r;

  // region size in bytes, doubled for two banks
  function automatic logic [11:0] footprint(input logic [2:0] size, input logic bank);
    logic [11:0] f;
    f = EP_SIZE_UNIT << size;
    if (bank) begin
      f = f << 1;
    end
    return f;
  endfunction : footprint

  logic [NUM_EP-1:0] endpoint_irq_summary;

  always_comb begin
    logic run;
    logic ep_ok;
    logic wr;
    logic found;
    logic [EPW-1:0] s;
    logic [11:0] lower_end;
    logic [11:0] top;
    logic [31:0] rd;
    logic hit;
    next_r = r;
    found = 1'b0;
    lower_end = '0;
    top = '0;
    rd = '0;
    hit = 1'b1;
    s = r.ep_sel;
    // time-relative logic only runs with the controller clock on
    run = r.macro_enable & ~r.clock_freeze;
    ep_ok = run & (int'(r.ep_sel) < NUM_EP);
    wr = PSEL & PENABLE & r.pready & PWRITE;
    for (int k = 0; k < NUM_EP; k++) begin
      endpoint_irq_summary[k] = |(r.ep_flag[k] & r.ep_ien[k]);
    end
    // apb: read data captured in setup, answered in the first access cycle
    next_r.pready = PSEL & ~PENABLE;
    next_r.pslverr = 1'b0;
    if (PSEL & ~PENABLE) begin
      case (PADDR)
        ADDR_GEN_CTRL: begin
          rd[GC_MACRO_ENABLE] = r.macro_enable;
          rd[GC_CLOCK_FREEZE] = r.clock_freeze;
          rd[GC_VBUS_PAD_ENABLE] = r.vbus_pad_enable;
          rd[GC_VBUS_TRANS_IE] = r.vbus_transition_irq_enable;
        end
        ADDR_PAD_REG: rd[PR_REG_ENABLE] = r.pad_regulator_enable;
        ADDR_GEN_STAT: begin
          rd[GS_ID] = 1'b1;
          rd[GS_VBUS] = r.vbus_status;
        end
        ADDR_GEN_IRQ: rd[GI_VBUS_TRANS] = r.vbus_transition_flag;
        ADDR_DEV_CTRL: begin
          rd[DC_DETACH] = r.detach;
          rd[DC_LOW_SPEED] = r.low_speed_select;
          rd[DC_CPU_RESET] = r.cpu_reset_enable;
        end
        ADDR_DEV_IRQ: begin
          rd[DI_SUSPEND] = r.suspend_flag;
          rd[DI_END_OF_RESET] = r.end_of_reset_flag;
          rd[DI_WAKEUP] = r.wakeup_flag;
        end
        ADDR_DEV_IEN: begin
          rd[DI_SUSPEND] = r.suspend_ie;
          rd[DI_END_OF_RESET] = r.end_of_reset_ie;
          rd[DI_WAKEUP] = r.wakeup_ie;
        end
        ADDR_EP_SEL: rd[EPW-1:0] = r.ep_sel;
        ADDR_EP_CFG: if (ep_ok) begin
          rd[EC_ENABLE] = r.endpoint_enable[s];
          rd[EC_RESERVE] = r.memory_reserve_bit[s];
          rd[EC_BANK] = r.endpoint_bank_count[s];
          rd[EC_SIZE_LSB +: 3] = r.endpoint_size_field[s];
        end
        ADDR_EP_STAT: if (ep_ok) begin
          rd[ES_CFG_OK] = r.configuration_ok_flag[s];
          rd[ES_BASE_LSB +: 11] = r.ep_base[s];
        end
        ADDR_EP_FLAG: if (ep_ok) rd[7:0] = r.ep_flag[s];
        ADDR_EP_IEN: if (ep_ok) rd[7:0] = r.ep_ien[s];
        ADDR_EP_SUM: if (run) rd[NUM_EP-1:0] = endpoint_irq_summary;
        default: hit = 1'b0;
      endcase
      next_r.prdata = rd;
      next_r.pslverr = ~hit;
    end
    // register writes; device registers held in reset while disabled
    if (wr) begin
      case (PADDR)
        ADDR_GEN_CTRL: begin
          next_r.macro_enable = PWDATA[GC_MACRO_ENABLE];
          next_r.clock_freeze = PWDATA[GC_CLOCK_FREEZE];
          next_r.vbus_pad_enable = PWDATA[GC_VBUS_PAD_ENABLE];
          next_r.vbus_transition_irq_enable = PWDATA[GC_VBUS_TRANS_IE];
        end
        ADDR_PAD_REG: next_r.pad_regulator_enable = PWDATA[PR_REG_ENABLE];
        ADDR_GEN_IRQ: if (!PWDATA[GI_VBUS_TRANS]) next_r.vbus_transition_flag = 1'b0;
        ADDR_DEV_CTRL: if (r.macro_enable) begin
          next_r.detach = PWDATA[DC_DETACH];
          next_r.low_speed_select = PWDATA[DC_LOW_SPEED];
          next_r.cpu_reset_enable = PWDATA[DC_CPU_RESET];
        end
        ADDR_DEV_IRQ: if (r.macro_enable) begin
          next_r.suspend_flag = r.suspend_flag & PWDATA[DI_SUSPEND];
          next_r.end_of_reset_flag = r.end_of_reset_flag & PWDATA[DI_END_OF_RESET];
          next_r.wakeup_flag = r.wakeup_flag & PWDATA[DI_WAKEUP];
        end
        ADDR_DEV_IEN: if (r.macro_enable) begin
          next_r.suspend_ie = PWDATA[DI_SUSPEND];
          next_r.end_of_reset_ie = PWDATA[DI_END_OF_RESET];
          next_r.wakeup_ie = PWDATA[DI_WAKEUP];
        end
        ADDR_EP_SEL: if (run) next_r.ep_sel = PWDATA[EPW-1:0];
        ADDR_EP_CFG: if (ep_ok) begin
          next_r.endpoint_enable[s] = PWDATA[EC_ENABLE];
          if (PWDATA[EC_RESERVE] && !r.memory_reserve_bit[s]) begin
            // insert after the highest reserved lower endpoint
            next_r.endpoint_size_field[s] = PWDATA[EC_SIZE_LSB +: 3];
            next_r.endpoint_bank_count[s] = PWDATA[EC_BANK];
            for (int i = 0; i < NUM_EP; i++) begin
              if (i < int'(s) && r.memory_reserve_bit[i]) begin
                lower_end = {1'b0, r.ep_base[i]} + footprint(r.endpoint_size_field[i],
                    r.endpoint_bank_count[i]);
              end
            end
            top = lower_end + footprint(PWDATA[EC_SIZE_LSB +: 3], PWDATA[EC_BANK]);
            next_r.ep_base[s] = lower_end[10:0];
            next_r.configuration_ok_flag[s] = (top <= DPRAM_BYTES);
            for (int i = 0; i < NUM_EP; i++) begin
              if (i > int'(s) && r.memory_reserve_bit[i] && !found) begin
                next_r.ep_base[i] = top[10:0];
                found = 1'b1;
              end
            end
          end else if (!PWDATA[EC_RESERVE] && r.memory_reserve_bit[s]) begin
            next_r.configuration_ok_flag[s] = 1'b0;
            next_r.endpoint_size_field[s] = PWDATA[EC_SIZE_LSB +: 3];
            next_r.endpoint_bank_count[s] = PWDATA[EC_BANK];
            for (int i = 0; i < NUM_EP; i++) begin
              if (i > int'(s) && r.memory_reserve_bit[i] && !found) begin
                next_r.ep_base[i] = r.ep_base[s];
                found = 1'b1;
              end
            end
          end else if (!PWDATA[EC_RESERVE]) begin
            next_r.endpoint_size_field[s] = PWDATA[EC_SIZE_LSB +: 3];
            next_r.endpoint_bank_count[s] = PWDATA[EC_BANK];
          end
          // unchanged reservation moves nothing
          next_r.memory_reserve_bit[s] = PWDATA[EC_RESERVE];
        end
        ADDR_EP_FLAG: if (ep_ok) next_r.ep_flag[s] = r.ep_flag[s] & PWDATA[7:0];
        ADDR_EP_IEN: if (ep_ok) next_r.ep_ien[s] = PWDATA[7:0];
        default: ;
      endcase
    end
    // vbus detection, independent of enable and freeze; set wins over clear
    if (r.vbus_pad_enable) begin
      next_r.vbus_status = VBUS_SESSION_VALID;
      if (VBUS_SESSION_VALID != r.vbus_status) begin
        next_r.vbus_transition_flag = 1'b1;
      end
    end else begin
      next_r.vbus_status = 1'b0;
    end
    next_r.line_prev = LINE_STATE;
    next_r.cpu_rst = 1'b0;
    // wakeup seen even when frozen; suspend only with clock running
    if (r.macro_enable && LINE_STATE != r.line_prev) begin
      next_r.wakeup_flag = 1'b1;
      next_r.suspend_flag = 1'b0;
      if (r.mode == MODE_SUSPENDED) next_r.mode = MODE_IDLE;
    end else if (run && SUSPEND_DET) begin
      next_r.suspend_flag = 1'b1;
      next_r.wakeup_flag = 1'b0;
      next_r.mode = MODE_SUSPENDED;
    end
    if (run && BUS_RESET_END) begin
      next_r.endpoint_enable[NUM_EP-1:1] = '0;
      if (r.cpu_reset_enable) begin
        // controller state reset, enable and attach kept
        next_r.cpu_rst = 1'b1;
        next_r.endpoint_enable = '0;
        next_r.memory_reserve_bit = '0;
        next_r.configuration_ok_flag = '0;
        next_r.ep_flag = '0;
        next_r.ep_ien = '0;
        next_r.ep_sel = '0;
        next_r.suspend_flag = 1'b0;
        next_r.wakeup_flag = 1'b0;
      end
      next_r.end_of_reset_flag = 1'b1;
    end
    if (run) begin
      for (int k = 0; k < NUM_EP; k++) begin
        next_r.ep_flag[k] = next_r.ep_flag[k] | EP_EVENT[k*EP_SRC_COUNT +: EP_SRC_COUNT];
      end
    end
    // clearing the macro enable is a controller reset
    if (!next_r.macro_enable) begin
      next_r.mode = MODE_RESET;
      next_r.detach = DC_RESET[DC_DETACH];
      next_r.low_speed_select = 1'b0;
      next_r.cpu_reset_enable = 1'b0;
      next_r.suspend_flag = 1'b0;
      next_r.end_of_reset_flag = 1'b0;
      next_r.wakeup_flag = 1'b0;
      next_r.suspend_ie = 1'b0;
      next_r.end_of_reset_ie = 1'b0;
      next_r.wakeup_ie = 1'b0;
      next_r.ep_sel = '0;
      next_r.endpoint_enable = '0;
      next_r.memory_reserve_bit = '0;
      next_r.endpoint_bank_count = '0;
      next_r.configuration_ok_flag = '0;
      next_r.endpoint_size_field = '0;
      next_r.ep_base = '0;
      next_r.ep_flag = '0;
      next_r.ep_ien = '0;
    end else if (r.mode == MODE_RESET) begin
      next_r.mode = MODE_IDLE;
    end
    // outputs, registered from the next state
    next_r.irq_gen = (next_r.vbus_transition_flag & next_r.vbus_transition_irq_enable)
        | (next_r.suspend_flag & next_r.suspend_ie)
        | (next_r.end_of_reset_flag & next_r.end_of_reset_ie)
        | (next_r.wakeup_flag & next_r.wakeup_ie);
    next_r.irq_ep = |(next_r.ep_flag & next_r.ep_ien);
    next_r.cpu_wake = next_r.irq_gen | next_r.irq_ep;
    next_r.sys_wake = (next_r.wakeup_flag & next_r.wakeup_ie)
        | (next_r.vbus_transition_flag & next_r.vbus_transition_irq_enable);
    next_r.xcvr_on = next_r.macro_enable;
    next_r.clk_en = next_r.macro_enable & ~next_r.clock_freeze;
    next_r.pad_idle = (next_r.mode != MODE_IDLE) | next_r.detach;
    next_r.pu_dp = next_r.macro_enable & ~next_r.detach & next_r.vbus_status
        & ~next_r.low_speed_select;
    next_r.pu_dm = next_r.macro_enable & ~next_r.detach & next_r.vbus_status
        & next_r.low_speed_select;
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      r <= '0;
      r.clock_freeze <= GC_RESET[GC_CLOCK_FREEZE];
      r.detach <= DC_RESET[DC_DETACH];
      r.mode <= MODE_RESET;
      r.pad_idle <= 1'b1;
    end else if (CE) begin
      r <= next_r;
    end
  end

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign IRQ_GENERAL = r.irq_gen;
  assign IRQ_ENDPOINT = r.irq_ep;
  assign CPU_WAKE = r.cpu_wake;
  assign SYS_WAKE = r.sys_wake;
  assign CPU_RESET_REQ = r.cpu_rst;
  assign XCVR_ON = r.xcvr_on;
  assign CTRL_CLOCK_EN = r.clk_en;
  assign PAD_IDLE = r.pad_idle;
  assign PULLUP_DP = r.pu_dp;
  assign PULLUP_DM = r.pu_dm;
  assign VBUS_PAD_ON = r.vbus_pad_enable;
  assign PAD_REG_ON = r.pad_regulator_enable;

  // config write with reserve, for coverage of the slide path
  logic wr_cfg_seen;
  assign wr_cfg_seen = PSEL && PENABLE && PWRITE && PADDR == ADDR_EP_CFG && PWDATA[EC_RESERVE];

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  chk_disabled_off: assert property (!r.macro_enable |-> !XCVR_ON && !CTRL_CLOCK_EN && PAD_IDLE)
    else $error("disabled controller not off");
  chk_freeze_clock: assert property (r.clock_freeze |-> !CTRL_CLOCK_EN)
    else $error("clock enabled while frozen");
  chk_speed_pullup: assert property ((PULLUP_DM |-> r.low_speed_select) and (PULLUP_DP |-> !r.low_speed_select))
    else $error("pull-up on wrong line");
  chk_no_vbus_attach: assert property (!r.vbus_status |-> !PULLUP_DP && !PULLUP_DM)
    else $error("attached without vbus");
  chk_vbus_edge_flag: assert property (CE && r.vbus_pad_enable && VBUS_SESSION_VALID != r.vbus_status |=> r.vbus_transition_flag && r.vbus_status == $past(VBUS_SESSION_VALID))
    else $error("vbus change not flagged");
  chk_wakeup_pad: assert property (CE && r.macro_enable && LINE_STATE != r.line_prev && !(PENABLE && PWRITE) |=> r.wakeup_flag && !r.suspend_flag && (r.detach || !PAD_IDLE))
    else $error("wakeup did not reactivate pad");
  chk_frozen_no_susp: assert property (CE && r.clock_freeze && !r.suspend_flag |=> !r.suspend_flag)
    else $error("suspend flagged while frozen");
  chk_detach_idle: assert property (r.detach |-> PAD_IDLE)
    else $error("pad active while detached");
  chk_ep_irq: assert property (IRQ_ENDPOINT == (|endpoint_irq_summary) || !r.macro_enable)
    else $error("endpoint irq mismatch");
  chk_cpu_wake: assert property (CPU_WAKE == (IRQ_GENERAL || IRQ_ENDPOINT))
    else $error("cpu wake mismatch");
  chk_ep0_fixed: assert property (r.memory_reserve_bit[0] |-> r.ep_base[0] == 11'h000)
    else $error("endpoint zero moved");
  chk_cpurst_attach: assert property (CPU_RESET_REQ |-> r.macro_enable && !$past(CPU_RESET_REQ))
    else $error("cpu reset dropped enable");
  chk_apb_answer: assert property (PSEL && !PENABLE && CE |=> PREADY)
    else $error("apb not answered");

  cov_memory_reserve_bit_slide: cover property (wr_cfg_seen);
  cov_suspend_wake: cover property (r.suspend_flag ##[1:50] r.wakeup_flag);
  cov_vbus_attach: cover property (!r.vbus_status ##1 (PULLUP_DP || PULLUP_DM));

endmodule : udgc_top

// file: inc/udgc_pkg.sv
// constants for the usb device general control block
package udgc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_GEN_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PAD_REG = 8'h04;
  localparam logic [7:0] ADDR_GEN_STAT = 8'h08;
  localparam logic [7:0] ADDR_GEN_IRQ = 8'h0c;
  localparam logic [7:0] ADDR_DEV_CTRL = 8'h10;
  localparam logic [7:0] ADDR_DEV_IRQ = 8'h14;
  localparam logic [7:0] ADDR_DEV_IEN = 8'h18;
  localparam logic [7:0] ADDR_EP_SEL = 8'h1c;
  localparam logic [7:0] ADDR_EP_CFG = 8'h20;
  localparam logic [7:0] ADDR_EP_STAT = 8'h24;
  localparam logic [7:0] ADDR_EP_FLAG = 8'h28;
  localparam logic [7:0] ADDR_EP_IEN = 8'h2c;
  localparam logic [7:0] ADDR_EP_SUM = 8'h30;
  // usb_general_control fields
  localparam int GC_MACRO_ENABLE = 7;
  localparam int GC_CLOCK_FREEZE = 5;
  localparam int GC_VBUS_PAD_ENABLE = 4;
  localparam int GC_VBUS_TRANS_IE = 0;
  localparam logic [7:0] GC_RESET = 8'h20;
  // pad_regulator_control, status and general irq fields
  localparam int PR_REG_ENABLE = 0;
  localparam int GS_ID = 1;
  localparam int GS_VBUS = 0;
  localparam int GI_VBUS_TRANS = 0;
  // device control fields
  localparam int DC_DETACH = 0;
  localparam int DC_LOW_SPEED = 2;
  localparam int DC_CPU_RESET = 3;
  localparam logic [7:0] DC_RESET = 8'h01;
  // device irq and irq enable fields
  localparam int DI_SUSPEND = 0;
  localparam int DI_END_OF_RESET = 3;
  localparam int DI_WAKEUP = 4;
  // endpoint config and status fields
  localparam int EC_ENABLE = 0;
  localparam int EC_RESERVE = 1;
  localparam int EC_BANK = 2;
  localparam int EC_SIZE_LSB = 4;
  localparam int ES_CFG_OK = 0;
  localparam int ES_BASE_LSB = 16;
  localparam int EP_SRC_COUNT = 8;
  localparam logic [11:0] EP_SIZE_UNIT = 12'h008;
  localparam logic [11:0] DPRAM_BYTES = 12'h340;
endpackage : udgc_pkg

// file: dv/udgc_host_model.sv
// behavioural usb host and vbus source facing the block
`timescale 1ns/1ps
module udgc_host_model (
  // bus lines
  input wire logic clk,
  output logic [1:0] line_state,
  output logic suspend_det,
  output logic reset_end,
  output logic vbus
);
  initial begin
    line_state = 2'b01;
    suspend_det = 1'b0;
    reset_end = 1'b0;
    vbus = 1'b0;
  end
  task pulse_suspend();
    suspend_det <= 1'b1;
    @(posedge clk);
    suspend_det <= 1'b0;
    @(posedge clk);
  endtask : pulse_suspend
  task pulse_reset_end();
    reset_end <= 1'b1;
    @(posedge clk);
    reset_end <= 1'b0;
    @(posedge clk);
  endtask : pulse_reset_end
  // resume signalling: k state then back to idle j
  task wiggle();
    line_state <= 2'b10;
    @(posedge clk);
    line_state <= 2'b01;
    @(posedge clk);
  endtask : wiggle
  task set_vbus(input logic v);
    vbus <= v;
    @(posedge clk);
  endtask : set_vbus
endmodule : udgc_host_model

// file: dv/udgc_bench.sv
// self-checking bench for the usb device general control block
`timescale 1ns/1ps
module udgc_bench;
  import udgc_pkg::*;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq_g, irq_e, cpu_wake, sys_wake, cpu_rst;
  logic xcvr, clk_en, pad_idle, pu_dp, pu_dm, vbus_on, reg_on;
  logic [1:0] ls;
  logic susp, rend, vbus;
  logic [55:0] ep_ev = 56'h0;
  logic [31:0] cfg [3];
  integer seed = 32'h9bee, n_errors = 0, checked = 0, cyc = 0, n_rst = 0;
  integer bytes [3];
  initial forever #20 mclk = ~mclk;
  udgc_top #(.NUM_EP(7)) dut (.MCLK(mclk), .NRST(nrst), .CE(1'b1),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LINE_STATE(ls), .SUSPEND_DET(susp), .BUS_RESET_END(rend),
    .VBUS_SESSION_VALID(vbus), .EP_EVENT(ep_ev), .IRQ_GENERAL(irq_g),
    .IRQ_ENDPOINT(irq_e), .CPU_WAKE(cpu_wake), .SYS_WAKE(sys_wake),
    .CPU_RESET_REQ(cpu_rst), .XCVR_ON(xcvr), .CTRL_CLOCK_EN(clk_en),
    .PAD_IDLE(pad_idle), .PULLUP_DP(pu_dp), .PULLUP_DM(pu_dm),
    .VBUS_PAD_ON(vbus_on), .PAD_REG_ON(reg_on));
  udgc_host_model host (.clk(mclk), .line_state(ls), .suspend_det(susp),
    .reset_end(rend), .vbus(vbus));
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cpu_rst === 1'b1) n_rst <= n_rst + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  task wrap_up();
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; waits for pready, then one idle edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    chk("pslverr", (a > 8'h30) ? 1 : 0, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge mclk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, r);
  endtask : rd
  function automatic integer ep_bytes(input logic [31:0] c);
    return (8 << c[6:4]) << c[2];
  endfunction : ep_bytes
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    rd(ADDR_GEN_CTRL, {24'h0, GC_RESET});
    rd(ADDR_DEV_CTRL, {24'h0, DC_RESET});
    chk("pad_idle", 1, pad_idle);
    chk("xcvr", 0, xcvr);
    rd(8'h40, 32'h0);
    wr(ADDR_PAD_REG, 32'h1);
    chk("reg_on", 1, reg_on);
    wr(ADDR_GEN_CTRL, 32'h31);
    chk("vbus_on", 1, vbus_on);
    host.set_vbus(1'b1);
    rd(ADDR_GEN_STAT, 32'h3);
    rd(ADDR_GEN_IRQ, 32'h1);
    chk("irq_g", 1, irq_g);
    chk("sys_wake", 1, sys_wake);
    chk("cpu_wake", 1, cpu_wake);
    wr(ADDR_GEN_IRQ, 32'h0);
    chk("irq_g", 0, irq_g);
    wr(ADDR_GEN_CTRL, 32'h91);
    chk("xcvr", 1, xcvr);
    chk("clk_en", 1, clk_en);
    wr(ADDR_DEV_IEN, 32'h19);
    wr(ADDR_DEV_CTRL, 32'h0);
    chk("dp", 1, pu_dp);
    chk("pad_idle", 0, pad_idle);
    wr(ADDR_DEV_CTRL, 32'h4);
    chk("dm", 1, pu_dm);
    chk("dp", 0, pu_dp);
    host.pulse_suspend();
    rd(ADDR_DEV_IRQ, 32'h1);
    chk("pad_idle", 1, pad_idle);
    host.wiggle();
    rd(ADDR_DEV_IRQ, 32'h10);
    chk("pad_idle", 0, pad_idle);
    wr(ADDR_DEV_IRQ, 32'h0);
    wr(ADDR_GEN_CTRL, 32'hb1);
    chk("clk_en", 0, clk_en);
    host.pulse_suspend();
    rd(ADDR_DEV_IRQ, 32'h0);
    host.wiggle();
    rd(ADDR_DEV_IRQ, 32'h10);
    wr(ADDR_DEV_IRQ, 32'h0);
    host.set_vbus(1'b0);
    rd(ADDR_GEN_IRQ, 32'h1);
    chk("dm", 0, pu_dm);
    wr(ADDR_GEN_IRQ, 32'h0);
    host.set_vbus(1'b1);
    wr(ADDR_GEN_CTRL, 32'h91);
    for (int k = 0; k < 3; k++) begin
      cfg[k] = {25'h0, 1'b0, 2'($random(seed)), 1'b0, 1'($random(seed)), 2'b11};
      bytes[k] = ep_bytes(cfg[k]);
      wr(ADDR_EP_SEL, k);
      wr(ADDR_EP_CFG, cfg[k]);
    end
    wr(ADDR_EP_SEL, 32'h2);
    rd(ADDR_EP_STAT, ((bytes[0] + bytes[1]) << 16) | 1);
    wr(ADDR_EP_SEL, 32'h1);
    wr(ADDR_EP_CFG, cfg[1] & ~32'h1);
    rd(ADDR_EP_CFG, cfg[1] & ~32'h1);
    wr(ADDR_EP_CFG, cfg[1] & ~32'h3);
    wr(ADDR_EP_SEL, 32'h2);
    rd(ADDR_EP_STAT, (bytes[0] << 16) | 1);
    wr(ADDR_EP_SEL, 32'h1);
    wr(ADDR_EP_CFG, cfg[1] | 32'h34);
    rd(ADDR_EP_STAT, (bytes[0] << 16) | 1);
    wr(ADDR_EP_SEL, 32'h2);
    rd(ADDR_EP_STAT, ((bytes[0] + ep_bytes(cfg[1] | 32'h34)) << 16) | 1);
    wr(ADDR_EP_SEL, 32'h0);
    rd(ADDR_EP_STAT, 32'h1);
    wr(ADDR_EP_IEN, 32'h1);
    ep_ev[0] <= 1'b1;
    @(posedge mclk);
    ep_ev[0] <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(ADDR_EP_FLAG, 32'h1);
    rd(ADDR_EP_SUM, 32'h1);
    chk("irq_e", 1, irq_e);
    wr(ADDR_EP_FLAG, 32'h0);
    wr(ADDR_DEV_CTRL, 32'h8);
    host.pulse_reset_end();
    repeat (2) @(posedge mclk);
    chk("cpu_rst", 1, n_rst);
    chk("xcvr", 1, xcvr);
    wr(ADDR_GEN_CTRL, 32'h11);
    chk("xcvr", 0, xcvr);
    rd(ADDR_DEV_CTRL, {24'h0, DC_RESET});
    wrap_up();
  end
endmodule : udgc_bench
